// ---- rtl/dcc_top.sv ----
`timescale 1ns/100ps
`include "dcc_defs.svh"
// How it works
// RQ1 - the output block offers transparent or double-buffered update, each with binary or two's-complement coding.
// RQ2 - two independent 12-bit output channels take codes read in the current coding mode.
// RQ3 - in two's-complement coding the top bit is inverted, so 000 becomes 800 and FFF becomes 7FF.
// RQ4 - the channel register takes 0 to 15 single-ended or 0 to 7 differential and starts at channel 0.
// RQ5 - the range register picks one of four gains, 1, 2, 4 or 8.
// RQ6 - the acquisition mode register sets trigger, scan and transfer, resetting to software trigger and polling.
// RQ7 - with autoscan on, the channel counts down to 0 after each conversion and reloads the start channel.
// RQ8 - with autoscan off, every trigger converts the programmed channel and leaves it unchanged.
// RQ9 - with the buffer enabled, every result is written into a 1024-word buffer unless the buffer is full, when it is dropped.
// RQ10 - the interrupt comes from external trigger, end of conversion, pacer or buffer half-full.
// RQ11 - a raised interrupt stays pending and blocks further ones until the host writes the clear port.
// RQ12 - a write to the software trigger port makes one conversion pulse, with the result at ports 4 and 5.
// RQ13 - reads of the buffer port return stored results in order.
// RQ14 - the data-ready bit goes low once a result is valid.
// RQ15 - transparent writes update the output at once; buffered writes wait in staging for an update write.
module dcc_top #(
  parameter int SAMPLE_W = `DCC_SAMPLE_W,
  parameter int FIFO_DEPTH = `DCC_FIFO_DEPTH
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic [3:0] host_addr_in,
  input wire logic [7:0] host_wdata_in,
  input wire logic host_wr_in,
  input wire logic host_rd_in,
  output logic [7:0] host_rdata_out,
  output logic host_rvalid_out,
  input wire logic diff_mode_in,
  input wire logic pacer_tick_in,
  input wire logic external_trigger_in,
  output logic conv_start_out,
  output logic [3:0] conv_channel_out,
  output logic [1:0] conv_gain_out,
  input wire logic conv_done_in,
  input wire logic [SAMPLE_W-1:0] conv_data_in,
  output logic [`DCC_DA_W-1:0] da0_out,
  output logic [`DCC_DA_W-1:0] da1_out,
  output logic [1:0] xfer_mode_out,
  output logic irq_out
);
  localparam int WORD_W = `DCC_WORD_W;

  dcc_pkg::dcc_out_mode_t da_mode;
  dcc_pkg::dcc_trig_t trig_src;
  dcc_pkg::dcc_xfer_t xfer_mode;
  dcc_pkg::dcc_irq_src_t irq_src;
  dcc_pkg::dcc_conv_state_t state;
  logic autoscan;
  logic fifo_en;
  logic [3:0] chan_start;
  logic [3:0] chan_active;
  logic [3:0] next_chan;
  logic [7:0] da_low [2];
  logic [`DCC_DA_W-1:0] da_stage [2];
  logic [`DCC_DA_W-1:0] da_level [2];
  logic [`DCC_DA_W-1:0] next_code;
  logic [SAMPLE_W-1:0] result;
  logic [WORD_W-1:0] res_wide;
  logic [WORD_W-1:0] head_wide;
  logic drdy_n;
  logic irq_pending;
  logic ext_prev;
  logic half_prev;
  logic ext_rise;
  logic half_rise;
  logic trig_evt;
  logic done_evt;
  logic irq_evt;
  logic da_wr_lo;
  logic da_wr_hi;
  logic da_sel;
  logic [7:0] next_rdata;

  dcc_fifo_if #(.W(SAMPLE_W)) fifo_bus ();

  dcc_fifo #(.W(SAMPLE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .fifo(fifo_bus.store)
  );

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      da_mode <= dcc_pkg::out_transparent_binary;
      trig_src <= dcc_pkg::trig_software; // RQ6
      xfer_mode <= dcc_pkg::xfer_polled; // RQ6
      autoscan <= 1'b0;
      fifo_en <= 1'b0;
      irq_src <= dcc_pkg::irq_from_ext_trigger;
      conv_gain_out <= 2'h0;
    end else if (host_wr_in) begin
      if (host_addr_in == `DCC_OFS_DA_MODE) begin
        da_mode <= dcc_pkg::dcc_out_mode_t'(host_wdata_in[1:0]); // RQ1
      end else if (host_addr_in == `DCC_OFS_GAIN) begin
        conv_gain_out <= host_wdata_in[1:0]; // RQ5
      end else if (host_addr_in == `DCC_OFS_ACQ_MODE) begin
        trig_src <= dcc_pkg::dcc_trig_t'(host_wdata_in[`DCC_ACQ_TRIG_LSB +: 2]); // RQ6
        autoscan <= host_wdata_in[`DCC_ACQ_AUTOSCAN_BIT];
        fifo_en <= host_wdata_in[`DCC_ACQ_FIFO_BIT];
        xfer_mode <= dcc_pkg::dcc_xfer_t'(host_wdata_in[`DCC_ACQ_XFER_LSB +: 2]);
      end else if (host_addr_in == `DCC_OFS_IRQ_SRC) begin
        irq_src <= dcc_pkg::dcc_irq_src_t'(host_wdata_in[1:0]); // RQ10
      end
    end
  end
  assign xfer_mode_out = xfer_mode;

  // ------------------------------------------------------------
  // output converters
  // ------------------------------------------------------------
  // decode converter byte writes
  always_comb begin
    da_wr_lo = 1'b0;
    da_wr_hi = 1'b0;
    da_sel = host_addr_in[1];
    if (!host_wr_in) begin
      da_wr_lo = 1'b0;
    end else if (host_addr_in == `DCC_OFS_DA0_LO || host_addr_in == `DCC_OFS_DA1_LO) begin
      da_wr_lo = 1'b1;
    end else if (host_addr_in == `DCC_OFS_DA0_HI || host_addr_in == `DCC_OFS_DA1_HI) begin
      da_wr_hi = 1'b1;
    end
    next_code = {host_wdata_in[3:0], da_low[da_sel]};
    if (da_mode[`DCC_DA_MODE_TWOS_BIT]) begin
      next_code[`DCC_DA_W-1] = ~host_wdata_in[3]; // RQ3
    end
  end

  // low byte waits, high byte completes the code per channel
  for (genvar ch = 0; ch < 2; ch++) begin : g_da
    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
        da_low[ch] <= 8'h00;
        da_stage[ch] <= `DCC_RST_DA;
        da_level[ch] <= `DCC_RST_DA;
      end else if (da_wr_lo && da_sel == 1'(ch)) begin
        da_low[ch] <= host_wdata_in; // RQ2
      end else if (da_wr_hi && da_sel == 1'(ch)) begin
        da_stage[ch] <= next_code; // RQ15
        if (!da_mode[`DCC_DA_MODE_BUF_BIT]) begin
          da_level[ch] <= next_code; // RQ15
        end
      end else if (host_wr_in && host_addr_in == `DCC_OFS_DA_UPDATE && da_mode[`DCC_DA_MODE_BUF_BIT]) begin
        da_level[ch] <= da_stage[ch]; // RQ15
      end
    end
  end
  assign da0_out = da_level[0];
  assign da1_out = da_level[1];

  // ------------------------------------------------------------
  // trigger and conversion sequence
  // ------------------------------------------------------------
  assign ext_rise = external_trigger_in & ~ext_prev;
  assign half_rise = fifo_bus.half_full & ~half_prev;
  assign done_evt = (state == dcc_pkg::conv_busy) & conv_done_in;
  always_comb begin
    trig_evt = 1'b0;
    case (trig_src)
      dcc_pkg::trig_software: trig_evt = host_wr_in && host_addr_in == `DCC_OFS_SOFT_TRIG; // RQ12
      dcc_pkg::trig_pacer: trig_evt = pacer_tick_in;
      dcc_pkg::trig_external: trig_evt = ext_rise;
      default: trig_evt = 1'b0;
    endcase
    if (!autoscan) begin
      next_chan = chan_start; // RQ8
    end else if (chan_active == `DCC_RST_CHANNEL) begin
      next_chan = chan_start; // RQ7
    end else begin
      next_chan = chan_active - `DCC_CHAN_STEP; // RQ7
    end
  end

  // sequencer, result and ready flag
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state <= dcc_pkg::conv_idle;
      conv_start_out <= 1'b0;
      result <= '0;
      drdy_n <= 1'b1;
      ext_prev <= 1'b0;
      half_prev <= 1'b0;
    end else begin
      ext_prev <= external_trigger_in;
      half_prev <= fifo_bus.half_full;
      conv_start_out <= 1'b0;
      case (state)
        dcc_pkg::conv_idle: begin
          if (trig_evt) begin
            conv_start_out <= 1'b1; // RQ12
            drdy_n <= 1'b1;
            state <= dcc_pkg::conv_busy;
          end
        end
        dcc_pkg::conv_busy: begin
          if (conv_done_in) begin
            result <= conv_data_in;
            drdy_n <= 1'b0; // RQ14
            state <= dcc_pkg::conv_idle;
          end
        end
        default: state <= dcc_pkg::conv_idle;
      endcase
    end
  end

  // channel select: host write wins over the scan step
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      chan_start <= `DCC_RST_CHANNEL; // RQ4
      chan_active <= `DCC_RST_CHANNEL;
    end else if (host_wr_in && host_addr_in == `DCC_OFS_CHANNEL) begin
      chan_start <= {host_wdata_in[`DCC_CHAN_DIFF_BIT] & ~diff_mode_in, host_wdata_in[2:0]}; // RQ4
      chan_active <= {host_wdata_in[`DCC_CHAN_DIFF_BIT] & ~diff_mode_in, host_wdata_in[2:0]};
    end else if (done_evt) begin
      chan_active <= next_chan; // RQ7
    end
  end
  assign conv_channel_out = chan_active;

  // result into the buffer, pops on the high byte read
  assign fifo_bus.wr_valid = done_evt & fifo_en; // RQ9
  assign fifo_bus.wr_data = conv_data_in;
  assign fifo_bus.rd_ready = host_rd_in && host_addr_in == `DCC_OFS_FIFO_HI; // RQ13

  // ------------------------------------------------------------
  // interrupt request
  // ------------------------------------------------------------
  always_comb begin
    case (irq_src)
      dcc_pkg::irq_from_ext_trigger: irq_evt = ext_rise; // RQ10
      dcc_pkg::irq_from_conv_done: irq_evt = done_evt;
      dcc_pkg::irq_from_pacer: irq_evt = pacer_tick_in;
      dcc_pkg::irq_from_buffer_half: irq_evt = half_rise;
      default: irq_evt = 1'b0;
    endcase
  end

  // pending holds until cleared; a new event beats the clear
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      irq_pending <= 1'b0;
    end else if (irq_evt) begin
      irq_pending <= 1'b1; // RQ11
    end else if (host_wr_in && host_addr_in == `DCC_OFS_IRQ_CLR) begin
      irq_pending <= 1'b0; // RQ11
    end
  end
  assign irq_out = irq_pending;

  // ------------------------------------------------------------
  // host read port
  // ------------------------------------------------------------
  assign res_wide = WORD_W'(result);
  assign head_wide = WORD_W'(fifo_bus.rd_data);
  always_comb begin
    next_rdata = 8'h00;
    if (host_addr_in == `DCC_OFS_FIFO_LO) begin
      next_rdata = head_wide[7:0];
    end else if (host_addr_in == `DCC_OFS_FIFO_HI) begin
      next_rdata = head_wide[15:8];
    end else if (host_addr_in == `DCC_OFS_RES_LO) begin
      next_rdata = res_wide[7:0]; // RQ12
    end else if (host_addr_in == `DCC_OFS_RES_HI) begin
      next_rdata = res_wide[15:8];
    end else if (host_addr_in == `DCC_OFS_STATUS) begin
      next_rdata[`DCC_ST_DRDY_N_BIT] = drdy_n; // RQ14
      next_rdata[`DCC_ST_IRQ_BIT] = irq_pending;
      next_rdata[`DCC_ST_EMPTY_BIT] = ~fifo_bus.rd_valid;
      next_rdata[`DCC_ST_HALF_BIT] = fifo_bus.half_full;
      next_rdata[`DCC_ST_FULL_BIT] = ~fifo_bus.wr_ready;
    end else if (host_addr_in == `DCC_OFS_CHANNEL) begin
      next_rdata = {4'h0, chan_active};
    end
  end

  // read data registered one cycle after the strobe
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      host_rdata_out <= 8'h00;
      host_rvalid_out <= 1'b0;
    end else begin
      host_rvalid_out <= host_rd_in;
      if (host_rd_in) begin
        host_rdata_out <= next_rdata;
      end
    end
  end

  a_twos_msb_flip: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // RQ3
    da_wr_hi && !da_sel && da_mode == dcc_pkg::out_transparent_twos
    |=> da0_out == {~$past(host_wdata_in[3]), $past(host_wdata_in[2:0]), $past(da_low[0])})
    else $error("two's-complement code not offset by mid-scale");
  a_transparent_now: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // RQ15
    da_wr_hi && da_sel && da_mode == dcc_pkg::out_transparent_binary
    |=> da1_out == {$past(host_wdata_in[3:0]), $past(da_low[1])})
    else $error("transparent write did not reach output");
  a_buffered_holds: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // RQ15
    da_wr_hi && !da_sel && da_mode[`DCC_DA_MODE_BUF_BIT]
    |=> $stable(da0_out) && da_stage[0][7:0] == $past(da_low[0]))
    else $error("buffered write changed output early");
  a_diff_chan_range: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // RQ4
    host_wr_in && host_addr_in == `DCC_OFS_CHANNEL && diff_mode_in |=> !conv_channel_out[`DCC_CHAN_DIFF_BIT])
    else $error("differential channel above 7");
  a_gain_select: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // RQ5
    host_wr_in && host_addr_in == `DCC_OFS_GAIN |=> conv_gain_out == $past(host_wdata_in[1:0]))
    else $error("gain not taken");
  a_scan_down: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // RQ7
    done_evt && autoscan && chan_active != 4'h0 && !(host_wr_in && host_addr_in == `DCC_OFS_CHANNEL)
    |=> chan_active == $past(chan_active) - 4'h1)
    else $error("autoscan did not step down");
  a_scan_wrap: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // RQ7
    done_evt && autoscan && chan_active == 4'h0 |=> chan_active == chan_start)
    else $error("autoscan did not reload start channel");
  a_single_chan: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // RQ8
    !autoscan && !(host_wr_in && host_addr_in == `DCC_OFS_CHANNEL) && chan_active == chan_start
    |=> chan_active == chan_start)
    else $error("channel moved with autoscan off");
  a_soft_trig_pulse: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // RQ12
    state == dcc_pkg::conv_idle && trig_src == dcc_pkg::trig_software
      && host_wr_in && host_addr_in == `DCC_OFS_SOFT_TRIG
    |=> conv_start_out && drdy_n ##1 !conv_start_out)
    else $error("software trigger pulse wrong");
  a_ready_low: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // RQ14
    done_evt |=> !drdy_n && result == $past(conv_data_in))
    else $error("result not valid with ready low");
  a_irq_pending_hold: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // RQ11
    irq_pending && !(host_wr_in && host_addr_in == `DCC_OFS_IRQ_CLR) |=> irq_pending)
    else $error("interrupt dropped without clear");
  a_irq_from_done: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // RQ10
    irq_src == dcc_pkg::irq_from_conv_done && done_evt |=> irq_out)
    else $error("end of conversion did not raise interrupt");
  a_fifo_capture: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // RQ9
    done_evt && fifo_en && fifo_bus.wr_ready |=> fifo_bus.rd_valid)
    else $error("result not stored in buffer");
endmodule

// ---- rtl/dcc_defs.svh ----
`ifndef DCC_DEFS_SVH
`define DCC_DEFS_SVH

// ----------------------------------------------------------------
// host port offsets
// ----------------------------------------------------------------
`define DCC_OFS_FIFO_LO 4'h0
`define DCC_OFS_FIFO_HI 4'h1
`define DCC_OFS_DA0_LO 4'h0
`define DCC_OFS_DA0_HI 4'h1
`define DCC_OFS_DA1_LO 4'h2
`define DCC_OFS_DA1_HI 4'h3
`define DCC_OFS_RES_LO 4'h4
`define DCC_OFS_RES_HI 4'h5
`define DCC_OFS_DA_MODE 4'h6
`define DCC_OFS_STATUS 4'h6
`define DCC_OFS_DA_UPDATE 4'h7
`define DCC_OFS_CHANNEL 4'h8
`define DCC_OFS_GAIN 4'h9
`define DCC_OFS_ACQ_MODE 4'ha
`define DCC_OFS_IRQ_SRC 4'hb
`define DCC_OFS_IRQ_CLR 4'hc
`define DCC_OFS_SOFT_TRIG 4'hd

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DCC_DA_MODE_TWOS_BIT 0
`define DCC_DA_MODE_BUF_BIT 1
`define DCC_ACQ_TRIG_LSB 0
`define DCC_ACQ_AUTOSCAN_BIT 2
`define DCC_ACQ_FIFO_BIT 3
`define DCC_ACQ_XFER_LSB 4
`define DCC_ST_DRDY_N_BIT 0
`define DCC_ST_IRQ_BIT 1
`define DCC_ST_EMPTY_BIT 2
`define DCC_ST_HALF_BIT 3
`define DCC_ST_FULL_BIT 4
`define DCC_CHAN_DIFF_BIT 3

// ----------------------------------------------------------------
// sizes and reset values
// ----------------------------------------------------------------
`define DCC_DA_W 12
`define DCC_SAMPLE_W 12
`define DCC_WORD_W 16
`define DCC_FIFO_DEPTH 1024
`define DCC_RST_CHANNEL 4'h0
`define DCC_RST_DA 12'h000
`define DCC_CHAN_STEP 4'h1

`endif

// ---- rtl/dcc_pkg.sv ----
package dcc_pkg;
  typedef enum logic [1:0] {
    out_transparent_binary = 2'b00,
    out_transparent_twos = 2'b01,
    out_buffered_binary = 2'b10,
    out_buffered_twos = 2'b11
  } dcc_out_mode_t;
  typedef enum logic [1:0] {
    trig_software = 2'b00,
    trig_pacer = 2'b01,
    trig_external = 2'b10,
    trig_none = 2'b11
  } dcc_trig_t;
  typedef enum logic [1:0] {
    xfer_polled = 2'b00,
    xfer_interrupt = 2'b01,
    xfer_dma = 2'b10,
    xfer_spare = 2'b11
  } dcc_xfer_t;
  typedef enum logic [1:0] {
    irq_from_ext_trigger = 2'b00,
    irq_from_conv_done = 2'b01,
    irq_from_pacer = 2'b10,
    irq_from_buffer_half = 2'b11
  } dcc_irq_src_t;
  typedef enum logic {
    conv_idle = 1'b0,
    conv_busy = 1'b1
  } dcc_conv_state_t;
endpackage

// ---- rtl/dcc_fifo_if.sv ----
`timescale 1ns/100ps
interface dcc_fifo_if #(parameter int W = 12);
  logic [W-1:0] wr_data;
  logic wr_valid;
  logic wr_ready;
  logic [W-1:0] rd_data;
  logic rd_valid;
  logic rd_ready;
  logic half_full;
  modport store (input wr_data, wr_valid, rd_ready, output wr_ready, rd_data, rd_valid, half_full);
  modport user (output wr_data, wr_valid, rd_ready, input wr_ready, rd_data, rd_valid, half_full);
endinterface

// ---- rtl/dcc_fifo.sv ----
`timescale 1ns/100ps
`include "dcc_defs.svh"
module dcc_fifo #(
  parameter int W = `DCC_SAMPLE_W,
  parameter int DEPTH = `DCC_FIFO_DEPTH
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  dcc_fifo_if.store fifo
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_COUNT = (AW+1)'(DEPTH);
  localparam logic [AW:0] HALF_COUNT = (AW+1)'(DEPTH / 2);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic wr_fire;
  logic rd_fire;

  // ------------------------------------------------------------
  // handshake and flags
  // ------------------------------------------------------------
  assign wr_fire = fifo.wr_valid & fifo.wr_ready;
  assign rd_fire = fifo.rd_valid & fifo.rd_ready;
  assign fifo.wr_ready = (count != FULL_COUNT);
  assign fifo.rd_valid = (count != '0);
  assign fifo.half_full = (count >= HALF_COUNT);
  assign fifo.rd_data = mem[rd_ptr]; // head of queue, oldest first RQ13

  // sample storage
  always_ff @(posedge clk_sys_in) begin
    if (wr_fire) begin
      mem[wr_ptr] <= fifo.wr_data; // RQ9
    end
  end

  // pointers
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (wr_fire) begin
        wr_ptr <= wr_ptr + AW'(1);
      end
      if (rd_fire) begin
        rd_ptr <= rd_ptr + AW'(1);
      end
    end
  end

  // fill level
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      count <= '0;
    end else if (wr_fire && !rd_fire) begin
      count <= count + (AW+1)'(1);
    end else if (rd_fire && !wr_fire) begin
      count <= count - (AW+1)'(1);
    end
  end

  a_fifo_push_count: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // RQ9
    wr_fire && !rd_fire |=> count == $past(count) + 1)
    else $error("fifo count did not rise on push");
  a_fifo_pop_order: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // RQ13
    rd_fire |=> rd_ptr == $past(rd_ptr) + AW'(1))
    else $error("fifo read pointer did not advance on pop");
  a_fifo_no_overfill: assert property (@(posedge clk_sys_in) disable iff (sys_rst_in) // RQ9
    count <= FULL_COUNT)
    else $error("fifo count beyond depth");
endmodule

// ---- tb/dcc_conv_model.sv ----
`timescale 1ns/100ps
// converter stand-in: answers each start after LAT cycles with a code that carries the channel
module dcc_conv_model #(
  parameter int LAT = 3
) (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic start_in,
  input wire logic [3:0] channel_in,
  output logic done_out,
  output logic [11:0] data_out
);
  int cnt;
  logic [3:0] ch;
  // count down from start, then present one result; the data bus toggles when not valid
  always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      cnt <= 0;
      ch <= 4'h0;
      done_out <= 1'b0;
      data_out <= 12'h000;
    end else begin
      done_out <= (cnt == 1);
      data_out <= (cnt == 1) ? {8'hc3, ch} : ~data_out;
      if (start_in) begin
        cnt <= LAT;
        ch <= channel_in;
      end else if (cnt > 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// ---- tb/dcc_top_test.sv ----
`timescale 1ns/100ps
module dcc_top_test;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [3:0] host_addr_in = 4'h0;
  logic [7:0] host_wdata_in = 8'h00;
  logic host_wr_in = 1'b0;
  logic host_rd_in = 1'b0;
  logic diff_mode_in = 1'b0;
  logic pacer_tick_in = 1'b0;
  logic external_trigger_in = 1'b0;
  logic [7:0] host_rdata_out, rd_v;
  logic host_rvalid_out, conv_start_out, conv_done_in, irq_out;
  logic [3:0] conv_channel_out;
  logic [1:0] conv_gain_out, xfer_mode_out;
  logic [11:0] conv_data_in, da0_out, da1_out;
  logic [3:0] chq[$];
  int fails = 0;
  int n_tests = 0;
  // rows: {mode, channel, code, expected output}
  logic [27:0] rows [6] = '{28'h0123123, 28'h1ffffff, 28'h4000800, 28'h5fff7ff, 28'h8456456, 28'hd800000};
  logic [11:0] prev [2] = '{12'h000, 12'h000};

  // 40 MHz clock
  always #12.5 clk_sys_in = ~clk_sys_in;

  dcc_top #(.FIFO_DEPTH(16)) i_dcc_top (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .host_addr_in(host_addr_in), .host_wdata_in(host_wdata_in), .host_wr_in(host_wr_in),
    .host_rd_in(host_rd_in), .host_rdata_out(host_rdata_out), .host_rvalid_out(host_rvalid_out),
    .diff_mode_in(diff_mode_in), .pacer_tick_in(pacer_tick_in), .external_trigger_in(external_trigger_in),
    .conv_start_out(conv_start_out), .conv_channel_out(conv_channel_out), .conv_gain_out(conv_gain_out),
    .conv_done_in(conv_done_in), .conv_data_in(conv_data_in), .da0_out(da0_out), .da1_out(da1_out),
    .xfer_mode_out(xfer_mode_out), .irq_out(irq_out));
  dcc_conv_model i_dcc_conv_model (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
    .start_in(conv_start_out), .channel_in(conv_channel_out), .done_out(conv_done_in), .data_out(conv_data_in));

  // record the channel of every conversion start
  always @(posedge clk_sys_in) begin
    if (conv_start_out === 1'b1) begin
      chq.push_back(conv_channel_out);
    end
  end

  // ----------------------------------------------------------------
  // host port tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    host_wr_in <= 1'b1;
    host_addr_in <= a;
    host_wdata_in <= d;
    @(posedge clk_sys_in);
    host_wr_in <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys_in);
    host_rd_in <= 1'b1;
    host_addr_in <= a;
    @(posedge clk_sys_in);
    host_rd_in <= 1'b0;
    #1;
    chk(16'(host_rvalid_out), 16'h0001);
    rd_v = host_rdata_out;
  endtask

  // software trigger, then poll the ready bit with a bounded count
  task automatic conv;
    int k;
    wr(4'hd, 8'h00);
    rd_v = 8'hff;
    for (k = 0; k < 20 && rd_v[0] !== 1'b0; k++) rd(4'h6);
    chk(16'(rd_v[0]), 16'h0000);
  endtask

  task automatic wrap_up;
    if (fails == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    fails++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    int i;
    logic [3:0] c;
    repeat (12) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    #1;
    chk(16'(da0_out), 16'h0000);
    chk(16'(xfer_mode_out | conv_gain_out), 16'h0000);
    rd(4'h8);
    chk(16'(rd_v), 16'h0000);
    rd(4'h6);
    chk(16'(rd_v), 16'h0005);
    for (i = 0; i < 6; i++) begin
      c = {2'b00, rows[i][24], 1'b0};
      wr(4'h6, {6'h00, rows[i][27:26]});
      wr(c, rows[i][19:12]);
      wr(c | 4'h1, {4'h0, rows[i][23:20]});
      if (rows[i][27]) begin
        chk(16'(rows[i][24] ? da1_out : da0_out), 16'(prev[rows[i][24]]));
        wr(4'h7, 8'h00);
      end
      chk(16'(rows[i][24] ? da1_out : da0_out), 16'(rows[i][11:0]));
      prev[rows[i][24]] = rows[i][11:0];
    end
    for (i = 0; i < 4; i++) begin
      wr(4'h9, 8'(i));
      chk(16'(conv_gain_out), 16'(i));
    end
    wr(4'ha, 8'h20);
    chk(16'(xfer_mode_out), 16'h0002);
    wr(4'ha, 8'h00);
    diff_mode_in <= 1'b1;
    wr(4'h8, 8'h0d);
    rd(4'h8);
    chk(16'(rd_v), 16'h0005);
    chq.delete();
    conv();
    conv();
    chk(16'(chq.size()), 16'h0002);
    chk(16'({chq[0], chq[1]}), 16'h0055);
    rd(4'h4);
    chk(16'(rd_v), 16'h0035);
    rd(4'h5);
    chk(16'(rd_v), 16'h000c);
    // pacer then external trigger source; a soft trigger is refused meanwhile
    chq.delete();
    wr(4'ha, 8'h01);
    wr(4'hd, 8'h00);
    @(posedge clk_sys_in);
    pacer_tick_in <= 1'b1;
    @(posedge clk_sys_in);
    pacer_tick_in <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
    wr(4'ha, 8'h02);
    @(posedge clk_sys_in);
    external_trigger_in <= 1'b1;
    @(posedge clk_sys_in);
    external_trigger_in <= 1'b0;
    repeat (8) @(posedge clk_sys_in);
    #1;
    chk(16'(chq.size()), 16'h0002);
    chk(16'(irq_out), 16'h0001);
    wr(4'ha, 8'h00);
    wr(4'hc, 8'h00);
    diff_mode_in <= 1'b0;
    for (i = 0; i < 3; i = i + 2) begin
      wr(4'hb, 8'(i));
      @(posedge clk_sys_in);
      if (i == 0) external_trigger_in <= 1'b1;
      else pacer_tick_in <= 1'b1;
      @(posedge clk_sys_in);
      external_trigger_in <= 1'b0;
      pacer_tick_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      #1;
      chk(16'(irq_out), 16'h0001);
      wr(4'hc, 8'h00);
      chk(16'(irq_out), 16'h0000);
    end
    wr(4'hb, 8'h01);
    conv();
    conv();
    chk(16'(irq_out), 16'h0001);
    wr(4'hc, 8'h00);
    chk(16'(irq_out), 16'h0000);
    wr(4'hb, 8'h03);
    wr(4'h8, 8'h02);
    wr(4'ha, 8'h0c);
    chq.delete();
    for (i = 0; i < 8; i++) conv();
    chk(16'(irq_out), 16'h0001);
    rd(4'h6);
    chk(16'(rd_v[3]), 16'h0001);
    for (i = 0; i < 8; i++) begin
      c = 4'(2 - (i % 3));
      chk(16'(chq[i]), 16'(c));
      rd(4'h0);
      chk(16'(rd_v), 16'({4'h3, c}));
      rd(4'h1);
      chk(16'(rd_v), 16'h000c);
    end
    rd(4'h6);
    chk(16'(rd_v[2]), 16'h0001);
    wrap_up();
  end
endmodule
